// ===== dv/sswd_host_model.sv
`timescale 1ns/10ps

module sswd_host_model (
    input wire logic clk,
    output logic sda_oe,
    output logic scl_oe
);
    // both lines released, pull-ups hold them high
    initial
    begin
        sda_oe = 1'b0;
        scl_oe = 1'b0;
    end

    task automatic start_cond();
        @(negedge clk);
        sda_oe = 1'b1;
        repeat (8) @(negedge clk);
        scl_oe = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    // stop: clock released first, then data released while clock high
    task automatic stop_cond();
        repeat (8) @(negedge clk);
        scl_oe = 1'b0;
        repeat (8) @(negedge clk);
        sda_oe = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ===== dv/sswd_top_props.sv
`timescale 1ns/10ps

module sswd_top_props #(
    parameter int HOLD_TICKS = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic pushbutton_reset_n_input,
    input wire logic write_protect,
    input wire logic reset_pin_n_oe,
    input wire logic reset_hi_oe,
    input wire logic bus_enable,
    input wire logic mem_enable,
    input wire logic mem_write_enable,
    input wire logic bus_abort,
    input wire logic write_cycle_busy,
    input wire logic watchdog_expired
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [15:0] oe_q;
    logic [7:0] pb_q;

    // run lengths of reset and of pushbutton low
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_q <= 16'h0000;
            pb_q <= 8'h00;
        end
        else
        begin
            oe_q <= reset_pin_n_oe ? oe_q + 16'h0001 : 16'h0000;
            pb_q <= pushbutton_reset_n_input ? 8'h00 : (pb_q == 8'hff ? pb_q : pb_q + 8'h01);
        end
    end

    a_outputs_agree: assert property (reset_pin_n_oe == reset_hi_oe)
        else $error("reset outputs disagree");
    a_supply_fast: assert property ((!supply_ok) [*8] |=> reset_pin_n_oe)
        else $error("supply fall not answered");
    a_push_fast: assert property (pb_q > 8'h14 |-> reset_pin_n_oe)
        else $error("pushbutton not answered");
    a_hold_min: assert property ($fell(reset_pin_n_oe) |-> $past(oe_q) >= (HOLD_TICKS - 1) * 125)
        else $error("reset released too early");
    a_mem_off: assert property (reset_pin_n_oe && $past(reset_pin_n_oe) |-> !mem_enable && !bus_enable)
        else $error("memory usable during reset");
    a_abort_reset: assert property (bus_abort |-> ##[0:1] (reset_pin_n_oe && !bus_enable))
        else $error("abort without reset");
    a_wdog_reset: assert property (watchdog_expired |=> reset_pin_n_oe)
        else $error("watchdog expiry gave no reset");
    a_wdog_quiet: assert property (reset_pin_n_oe |-> !watchdog_expired)
        else $error("watchdog fired during reset");
    a_wp_blocks: assert property (write_protect |-> !mem_write_enable)
        else $error("write allowed while protected");
    a_busy_no_bus: assert property (write_cycle_busy && $past(write_cycle_busy) |-> !bus_enable)
        else $error("bus open during write cycle");
endmodule

// ===== dv/supply_supervisor_watchdog_bench.sv
`timescale 1ns/10ps

module supply_supervisor_watchdog_bench;
    localparam int TK = 125;
    localparam int HC = 20 * TK;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b0;
    logic pb_n = 1'b1;
    logic ext_pull = 1'b0;
    logic wr_req = 1'b0;
    logic wp = 1'b0;
    logic kick = 1'b0;
    int wd_cnt = 0;
    int ab_cnt = 0;
    int base;
    logic sda_oe, scl_oe, pin_oe, pin_out, hi_out, hi_oe, bus_en, mem_en, mem_we, abort, busy, wd_exp;
    int num_errors = 0;
    int checked = 0;
    int n;
    int m;

    sswd_host_model host (.clk(clk), .sda_oe(sda_oe), .scl_oe(scl_oe));
    sswd_top #(.HOLD_TICKS(20), .WDOG_TICKS(50), .WCYC_TICKS(10)) dut (
        .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .pushbutton_reset_n_input(pb_n),
        .watchdog_kick_input(kick), .write_protect(wp), .reset_pin_n_in(~(pin_oe | ext_pull)),
        .reset_pin_n_out(pin_out), .reset_pin_n_oe(pin_oe), .reset_hi_out(hi_out), .reset_hi_oe(hi_oe),
        .sda_in(~sda_oe), .scl_in(~scl_oe), .write_request(wr_req), .bus_enable(bus_en),
        .mem_enable(mem_en), .mem_write_enable(mem_we), .bus_abort(abort),
        .write_cycle_busy(busy), .watchdog_expired(wd_exp));

    // clock and pulse catchers
    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (wd_exp === 1'b1) wd_cnt <= wd_cnt + 1;
        if (abort === 1'b1) ab_cnt <= ab_cnt + 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_oe(input logic v, input int lim, output int k);
        k = 0;
        while (pin_oe !== v && k < lim)
        begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic in_hold(input string what, input int k);
        check(what, k >= HC - TK && k <= HC + TK + 40, 1'b1);
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && checked > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic t_power_up();
        cyc(20);
        check("oe low supply", pin_oe, 1'b1);
        supply_ok = 1'b1;
        wait_oe(1'b0, 4000, n);
        in_hold("power hold", n);
        check("hi released", hi_oe, 1'b0);
        check("pin drive", pin_out, 1'b0);
        check("hi drive", hi_out, 1'b1);
        check("mem on", mem_en, 1'b1);
    endtask
    task automatic t_supply();
        supply_ok = 1'b0;
        cyc(3);
        supply_ok = 1'b1;
        cyc(30);
        check("glitch", pin_oe, 1'b0);
        supply_ok = 1'b0;
        wait_oe(1'b1, 625, n);
        check("fall delay", n < 625, 1'b1);
        cyc(3);
        check("mem off", mem_en, 1'b0);
        supply_ok = 1'b1;
        wait_oe(1'b0, 4000, n);
        in_hold("brown hold", n);
    endtask
    task automatic t_push();
        pb_n = 1'b0;
        cyc(1);
        pb_n = 1'b1;
        cyc(30);
        check("push glitch", pin_oe, 1'b0);
        pb_n = 1'b0;
        wait_oe(1'b1, 125, n);
        check("push delay", n < 125, 1'b1);
        cyc(3000);
        check("push held", pin_oe, 1'b1);
        pb_n = 1'b1;
        wait_oe(1'b0, 4000, n);
        in_hold("push hold", n);
    endtask
    task automatic t_pin();
        // let the released pin be seen high before pulling it
        cyc(40);
        ext_pull = 1'b1;
        cyc(20);
        ext_pull = 1'b0;
        wait_oe(1'b0, 4000, n);
        in_hold("pin hold", n + 20);
        check("pin seen", n > HC - 200, 1'b1);
    endtask
    // bus used only after reset ends
    task automatic t_bus();
        host.start_cond();
        check("start", bus_en, 1'b1);
        check("we open", mem_we, 1'b1);
        host.stop_cond();
        check("stop", bus_en, 1'b0);
        host.start_cond();
        base = ab_cnt;
        pb_n = 1'b0;
        cyc(40);
        check("abort", ab_cnt - base, 1);
        host.stop_cond();
        host.start_cond();
        check("refused", bus_en, 1'b0);
        host.stop_cond();
        pb_n = 1'b1;
        wait_oe(1'b0, 4000, n);
    endtask
    task automatic t_write();
        wr_req = 1'b1;
        cyc(1);
        wr_req = 1'b0;
        cyc(2);
        check("busy", busy, 1'b1);
        host.start_cond();
        check("bus off busy", bus_en, 1'b0);
        host.stop_cond();
        wait (busy === 1'b0);
        cyc(1);
        wr_req = 1'b1;
        cyc(1);
        wr_req = 1'b0;
        pb_n = 1'b0;
        m = 1;
        while (busy === 1'b1 && m < 2000)
        begin
            @(negedge clk);
            m++;
        end
        check("cycle finishes", m >= 1125 && m <= 1400, 1'b1);
        wr_req = 1'b1;
        cyc(3);
        wr_req = 1'b0;
        check("no write in reset", busy, 1'b0);
        pb_n = 1'b1;
        wait_oe(1'b0, 4000, n);
        wp = 1'b1;
        wr_req = 1'b1;
        cyc(3);
        wr_req = 1'b0;
        check("protected", busy, 1'b0);
        host.start_cond();
        check("we gated", mem_we, 1'b0);
        host.stop_cond();
        wp = 1'b0;
    endtask
    task automatic t_wdog();
        base = wd_cnt;
        repeat (8)
        begin
            host.start_cond();
            host.stop_cond();
            cyc(1000);
        end
        check("kicked", wd_cnt - base, 0);
        host.start_cond();
        host.stop_cond();
        n = 0;
        // kick line toggles but the data-line variant must ignore it
        while (wd_cnt == base && n < 7000)
        begin
            @(negedge clk);
            kick = ~kick;
            n++;
        end
        check("wdog time", n >= 6000 && n <= 6400, 1'b1);
        check("kick ignored", n >= 6000, 1'b1);
        check("wdog reset", pin_oe, 1'b1);
        wait_oe(1'b0, 4000, n);
        in_hold("wdog hold", n);
    endtask

    // run limit
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        cyc(10);
        rst_n = 1'b1;
        t_power_up();
        t_supply();
        t_push();
        t_pin();
        t_bus();
        t_write();
        t_wdog();
        tally_and_finish();
    end
endmodule

bind sswd_top sswd_top_props #(.HOLD_TICKS(HOLD_TICKS)) props (
    .clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .pushbutton_reset_n_input(pushbutton_reset_n_input),
    .write_protect(write_protect), .reset_pin_n_oe(reset_pin_n_oe), .reset_hi_oe(reset_hi_oe),
    .bus_enable(bus_enable), .mem_enable(mem_enable), .mem_write_enable(mem_write_enable),
    .bus_abort(bus_abort), .write_cycle_busy(write_cycle_busy), .watchdog_expired(watchdog_expired));

// ===== hdl/sswd_bus_cond.sv
`timescale 1ns/10ps

module sswd_bus_cond (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_level,
    output logic start_seen,
    output logic stop_seen
);

    sswd_pkg::sswd_cond_t s_q;
    sswd_pkg::sswd_cond_t s_d;

    // shift both lines through sync and one history stage
    always_comb
    begin
        s_d.sda = {s_q.sda[1:0], sda_in};
        s_d.scl = {s_q.scl[1:0], scl_in};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{sda: 3'h7, scl: 3'h7};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // data edges while clock high are conditions, not data
    // edge under high clock
    assign start_seen = s_q.sda[2] & ~s_q.sda[1] & s_q.scl[2] & s_q.scl[1];
    assign stop_seen = ~s_q.sda[2] & s_q.sda[1] & s_q.scl[2] & s_q.scl[1];
    assign sda_level = s_q.sda[1];

endmodule

// ===== hdl/sswd_filter.sv
`timescale 1ns/10ps
`include "sswd_regs.svh"

module sswd_filter #(
    parameter int STABLE_CYC = 1,
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw_in,
    output logic level
);

    localparam logic [`SSWD_FILT_W-1:0] STABLE_LD = `SSWD_FILT_W'(STABLE_CYC - 1);

    sswd_pkg::sswd_filt_t s_q;
    sswd_pkg::sswd_filt_t s_d;

    // two-flop sync, then level accepted after a stable run
    always_comb
    begin
        s_d = s_q;
        s_d.sync = {s_q.sync[0], raw_in};
        if (s_q.sync[1] == s_q.level)
        begin
            s_d.cnt = STABLE_LD;
        end
        else if (s_q.cnt == '0)
        begin
            s_d.level = s_q.sync[1];
            s_d.cnt = STABLE_LD;
        end
        else
        begin
            s_d.cnt = s_q.cnt - `SSWD_FILT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{sync: {2{RESET_LEVEL}}, level: RESET_LEVEL, cnt: STABLE_LD};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level = s_q.level;

endmodule

// ===== hdl/sswd_top.sv
`timescale 1ns/10ps
`include "sswd_regs.svh"

module sswd_top #(
    parameter int HOLD_TICKS = `SSWD_HOLD_MS * 1000,
    parameter int WDOG_TICKS = `SSWD_WDOG_MS * 1000,
    parameter int WCYC_TICKS = `SSWD_WCYC_MS * 1000,
    parameter bit WDOG_ON_KICK = 1'b0,
    parameter bit HAS_WP = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic supply_ok,
    input wire logic pushbutton_reset_n_input,
    input wire logic watchdog_kick_input,
    input wire logic write_protect,
    input wire logic reset_pin_n_in,
    output logic reset_pin_n_out,
    output logic reset_pin_n_oe,
    output logic reset_hi_out,
    output logic reset_hi_oe,
    input wire logic sda_in,
    input wire logic scl_in,
    input wire logic write_request,
    output logic bus_enable,
    output logic mem_enable,
    output logic mem_write_enable,
    output logic bus_abort,
    output logic write_cycle_busy,
    output logic watchdog_expired
);

    // time base prescale, 1 us per tick
    localparam int TICK_CYC = `SSWD_TICK_NS / `SSWD_CLK_NS;
    localparam logic [`SSWD_PRE_W-1:0] PRE_LAST = `SSWD_PRE_W'(TICK_CYC - 1);

    // glitch widths rounded up to whole clock cycles
    localparam int SUPPLY_CYC = (`SSWD_SUPPLY_GLITCH_NS + `SSWD_CLK_NS - 1) / `SSWD_CLK_NS;
    localparam int PUSH_CYC = (`SSWD_PUSH_GLITCH_NS + `SSWD_CLK_NS - 1) / `SSWD_CLK_NS;

    // interval loads at counter width
    localparam logic [`SSWD_CNT_W-1:0] HOLD_LD = `SSWD_CNT_W'(HOLD_TICKS);
    localparam logic [`SSWD_CNT_W-1:0] WDOG_LIM = `SSWD_CNT_W'(WDOG_TICKS);
    localparam logic [`SSWD_CNT_W-1:0] WCYC_LD = `SSWD_CNT_W'(WCYC_TICKS);
    localparam logic [`SSWD_CNT_W-1:0] ONE = `SSWD_CNT_W'(1);

    sswd_pkg::sswd_top_t s_q;
    sswd_pkg::sswd_top_t s_d;

    logic supply_f;
    logic push_f;
    logic pin_f;
    logic kick_f;
    logic sda_f;
    logic start_seen;
    logic stop_seen;
    logic tick;
    logic cause;
    logic pin_fall;
    logic wd_line;
    logic wd_edge;
    logic wp_block;

    // supply comparator, low while below threshold
    // glitch rejection
    sswd_filter #(
        .STABLE_CYC(SUPPLY_CYC),
        .RESET_LEVEL(1'b0)
    ) u_supply (
        .clk(clk),
        .rst_n(rst_n),
        .raw_in(supply_ok),
        .level(supply_f)
    );

    // pushbutton input
    // debounce under 100 ns
    sswd_filter #(
        .STABLE_CYC(PUSH_CYC),
        .RESET_LEVEL(1'b1)
    ) u_push (
        .clk(clk),
        .rst_n(rst_n),
        .raw_in(pushbutton_reset_n_input),
        .level(push_f)
    );

    // reset pin read back as an input
    sswd_filter #(
        .STABLE_CYC(PUSH_CYC),
        .RESET_LEVEL(1'b0)
    ) u_pin (
        .clk(clk),
        .rst_n(rst_n),
        .raw_in(reset_pin_n_in),
        .level(pin_f)
    );

    // dedicated kick line
    // synchronised input
    sswd_filter #(
        .STABLE_CYC(`SSWD_PLAIN_CYC),
        .RESET_LEVEL(1'b0)
    ) u_kick (
        .clk(clk),
        .rst_n(rst_n),
        .raw_in(watchdog_kick_input),
        .level(kick_f)
    );

    // serial bus conditions and synchronised data line
    sswd_bus_cond u_cond (
        .clk(clk),
        .rst_n(rst_n),
        .sda_in(sda_in),
        .scl_in(scl_in),
        .sda_level(sda_f),
        .start_seen(start_seen),
        .stop_seen(stop_seen)
    );

    // event terms
    // interval tick
    assign tick = (s_q.pre == PRE_LAST);
    assign wd_line = WDOG_ON_KICK ? kick_f : sda_f;
    assign wd_edge = wd_line ^ s_q.wd_d;
    assign pin_fall = s_q.pin_d & ~pin_f;
    assign wp_block = HAS_WP & write_protect;
    assign cause = ~supply_f | ~push_f;

    // next-state of the supervisor
    always_comb
    begin
        s_d = s_q;
        s_d.abort = 1'b0;
        s_d.wdog_fire = 1'b0;
        s_d.pin_d = pin_f;
        s_d.wd_d = wd_line;
        s_d.pre = tick ? '0 : s_q.pre + `SSWD_PRE_W'(1);

        // watchdog counts ticks of silence on the watched line
        // cleared during reset
        if (s_q.rst_out || wd_edge)
        begin
            s_d.wdog = '0;
        end
        else if (tick)
        begin
            if (s_q.wdog >= WDOG_LIM - ONE)
            begin
                s_d.wdog = '0;
                s_d.wdog_fire = 1'b1;
            end
            else
            begin
                s_d.wdog = s_q.wdog + ONE;
            end
        end

        // reset state machine
        case (s_q.st)
            sswd_pkg::SSWD_POWER_LOW:
            begin
                s_d.hold = HOLD_LD;
                if (!cause)
                begin
                    s_d.st = sswd_pkg::SSWD_HOLD;
                end
            end
            sswd_pkg::SSWD_HOLD:
            begin
                if (cause)
                begin
                    s_d.st = sswd_pkg::SSWD_POWER_LOW;
                end
                else if (pin_fall)
                begin
                    s_d.hold = HOLD_LD;
                end
                else if (tick)
                begin
                    if (s_q.hold <= ONE)
                    begin
                        s_d.st = sswd_pkg::SSWD_RUN;
                        s_d.hold = '0;
                    end
                    else
                    begin
                        s_d.hold = s_q.hold - ONE;
                    end
                end
            end
            sswd_pkg::SSWD_RUN:
            begin
                if (cause)
                begin
                    s_d.st = sswd_pkg::SSWD_POWER_LOW;
                end
                else if (pin_fall || s_q.wdog_fire)
                begin
                    s_d.st = sswd_pkg::SSWD_HOLD;
                    s_d.hold = HOLD_LD;
                end
            end
            default:
            begin
                s_d.st = sswd_pkg::SSWD_POWER_LOW;
            end
        endcase

        s_d.rst_out = (s_d.st != sswd_pkg::SSWD_RUN);

        // internal write cycle runs to completion regardless of reset
        // finish running cycle
        if (s_q.wcyc != '0)
        begin
            if (tick)
            begin
                s_d.wcyc = s_q.wcyc - ONE;
            end
        end
        else if (write_request && !s_q.rst_out && !wp_block)
        begin
            s_d.wcyc = WCYC_LD;
        end

        // transaction window opened by START, closed by STOP
        // abort and refuse during reset
        if (s_q.rst_out || s_q.wcyc != '0)
        begin
            s_d.abort = s_q.bus_open & s_q.rst_out;
            s_d.bus_open = 1'b0;
        end
        else if (start_seen)
        begin
            s_d.bus_open = 1'b1;
        end
        else if (stop_seen)
        begin
            s_d.bus_open = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{st: sswd_pkg::SSWD_POWER_LOW, pre: '0, hold: '0, wdog: '0, wcyc: '0,
                     pin_d: 1'b0, wd_d: ~WDOG_ON_KICK, bus_open: 1'b0, rst_out: 1'b1, abort: 1'b0,
                     wdog_fire: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // open-drain active-low pin, and active-high pin driven high only in reset, both from the registered reset state
    // shared source
    assign reset_pin_n_out = 1'b0;
    assign reset_pin_n_oe = s_q.rst_out;
    assign reset_hi_out = 1'b1;
    assign reset_hi_oe = s_q.rst_out;

    // memory gating
    // disabled under reset
    assign mem_enable = ~s_q.rst_out;
    assign bus_enable = s_q.bus_open;
    assign mem_write_enable = s_q.bus_open & ~wp_block;
    assign bus_abort = s_q.abort;
    assign write_cycle_busy = (s_q.wcyc != '0);
    assign watchdog_expired = s_q.wdog_fire;

endmodule

// ===== shared/sswd_pkg.sv
`include "sswd_regs.svh"

package sswd_pkg;

    // supervisor states
    typedef enum logic [1:0] {
        SSWD_POWER_LOW,
        SSWD_HOLD,
        SSWD_RUN
    } sswd_state_t;

    // glitch filter state
    typedef struct packed {
        logic [1:0] sync;
        logic level;
        logic [`SSWD_FILT_W-1:0] cnt;
    } sswd_filt_t;

    // bus condition detector state
    typedef struct packed {
        logic [2:0] sda;
        logic [2:0] scl;
    } sswd_cond_t;

    // supervisor state
    typedef struct packed {
        sswd_state_t st;
        logic [`SSWD_PRE_W-1:0] pre;
        logic [`SSWD_CNT_W-1:0] hold;
        logic [`SSWD_CNT_W-1:0] wdog;
        logic [`SSWD_CNT_W-1:0] wcyc;
        logic pin_d;
        logic wd_d;
        logic bus_open;
        logic rst_out;
        logic abort;
        logic wdog_fire;
    } sswd_top_t;

endpackage

// ===== shared/sswd_regs.svh
`ifndef SSWD_REGS_SVH
`define SSWD_REGS_SVH

// clock period and time base
`define SSWD_CLK_NS 8
`define SSWD_TICK_NS 1000
`define SSWD_PRE_W 8

// interval counters, in time base ticks of 1 us
`define SSWD_CNT_W 21
`define SSWD_HOLD_MS 200
`define SSWD_WDOG_MS 1600
`define SSWD_WCYC_MS 5

// glitch rejection widths
`define SSWD_SUPPLY_GLITCH_NS 30
`define SSWD_PUSH_GLITCH_NS 100
`define SSWD_FILT_W 8

// monitored line sync, no extra filtering
`define SSWD_PLAIN_CYC 1

`endif
